/* File: verilog/rrb_dma.v */
// receive ring-of-pages dma: stores mac frames into 256-byte pages of buffer ram
// assumes a mac on the same clock giving start, byte and end strobes, an 8-bit ram
// write port that never stalls, and host software on a plain register port
//
// How it works
// - list mode bit selects ring or list
// - frames go into circular 256-byte pages
// - first page starts ring, end page excluded
// - four-byte header opens each frame's page
// - header: status, next page, count low, high
// - reaching end page wraps to first page
// - frames span many pages, up to 254
// - write pointer names frame start or next
// - write pointer advances only at frame end
// - protect pointer names page not overwritten unless ring empty
// - opening protected page aborts, flags overwrite, missed
// - equal pointers: last updater decides full/empty
// - pointers outside ring give no guarantee
// - ring empty status bit readable at bit 2
`timescale 1ns/10ps
`include "rrb_defines.vh"

module rrb_dma (
    input  wire        ref_clk_in,
    input  wire        rst_in,
    // register port
    input  wire [3:0]  reg_addr_in,
    input  wire [7:0]  reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [7:0]  reg_rdata_out,
    // mac receive stream, same clock
    input  wire        rx_start_in,
    input  wire        rx_byte_valid_in,
    input  wire [7:0]  rx_byte_in,
    input  wire        rx_end_in,
    input  wire [7:0]  rx_status_in,
    output wire        rx_abort_out,
    // buffer ram write port
    output reg         mem_wr_out,
    output reg  [15:0] mem_addr_out,
    output reg  [7:0]  mem_data_out,
    // mode and interrupt
    output wire        list_mode_select_out,
    output wire        irq_out
);

    // =====================================================================
    // states
    localparam [1:0] ST_IDLE  = 2'd0;
    localparam [1:0] ST_STORE = 2'd1;
    localparam [1:0] ST_HDR   = 2'd2;
    localparam [1:0] ST_DROP  = 2'd3;

    // =====================================================================
    // registers
    reg  [7:0]  ring_first_page_q;
    reg  [7:0]  ring_end_page_q;
    reg  [7:0]  write_page_pointer_q;
    reg  [7:0]  protect_page_q;
    reg  [7:0]  extension_register_q;
    reg  [1:0]  int_flags_q;
    reg  [1:0]  int_mask_q;
    reg  [7:0]  rx_result_q;
    reg         host_last_q;          // host touched a pointer after the dma did
    reg  [1:0]  state_q;
    reg  [7:0]  page_q;
    reg  [7:0]  offset_q;
    reg         need_open_q;
    reg  [15:0] count_q;
    reg  [1:0]  hdr_idx_q;
    reg  [7:0]  status_q;
    reg  [7:0]  next_page_q;
    reg         abort_q;

    // =====================================================================
    // page arithmetic
    // next page in the ring; the end page itself is returned only when it equals the first page
    function [7:0] ring_next;
        input [7:0] page;
        input [7:0] first;
        input [7:0] last_excl;
        reg   [7:0] inc;
        begin
            // a page outside the ring just counts up, wrapping past 8'hff, until it meets the end page,
            // so frames stored from there land wherever the count leads
            inc = page + 8'h01;
            ring_next = (inc == last_excl) ? first : inc;
        end
    endfunction

    wire list_mode  = extension_register_q[`RRB_EXT_LIST_MODE];
    wire ptr_equal  = (protect_page_q == write_page_pointer_q);
    // equal pointers alone are ambiguous; host_last_q breaks the tie
    wire ring_empty = ptr_equal & host_last_q;
    wire ring_full  = ptr_equal & ~host_last_q;
    wire host_wr_write_ptr   = reg_wr_in && (reg_addr_in == `RRB_OFF_WRITE_PTR);
    wire host_wr_protect_ptr = reg_wr_in && (reg_addr_in == `RRB_OFF_PROTECT_PTR);

    // a page about to be opened that the protect pointer guards; a protect
    // pointer outside the ring matches only pages reached from a write pointer outside it
    wire open_blocked = need_open_q && (page_q == protect_page_q);
    wire start_go     = rx_start_in && !list_mode;
    wire start_block  = ring_full;
    wire overwrite_event = (state_q == ST_IDLE && start_go && start_block) ||
                        (state_q == ST_STORE && rx_byte_valid_in && open_blocked);
    wire done_event   = (state_q == ST_HDR) && (hdr_idx_q == `RRB_HDR_COUNT_HI);

    assign rx_abort_out         = abort_q;
    assign list_mode_select_out = list_mode;
    assign irq_out              = |(int_flags_q & int_mask_q);

    // =====================================================================
    // frame engine: data bytes then header, pointer moves only at the end
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q      <= ST_IDLE;
            page_q       <= `RRB_RST_PAGE;
            offset_q     <= `RRB_RST_BYTE;
            need_open_q  <= 1'b0;
            count_q      <= 16'h0000;
            hdr_idx_q    <= 2'b00;
            status_q     <= `RRB_RST_BYTE;
            next_page_q  <= `RRB_RST_PAGE;
            abort_q      <= 1'b0;
            mem_wr_out   <= 1'b0;
            mem_addr_out <= 16'h0000;
            mem_data_out <= 8'h00;
        end else begin
            mem_wr_out <= 1'b0;
            abort_q    <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (start_go) begin
                        if (start_block) begin
                            abort_q <= 1'b1;
                            state_q <= ST_DROP;
                        end else begin
                            page_q      <= write_page_pointer_q;
                            offset_q    <= `RRB_HDR_LEN;
                            need_open_q <= 1'b0;
                            count_q     <= 16'h0000;
                            state_q     <= ST_STORE;
                        end
                    end
                end
                ST_STORE: begin
                    if (rx_byte_valid_in) begin
                        if (open_blocked) begin
                            // protected page left untouched
                            abort_q <= 1'b1;
                            state_q <= rx_end_in ? ST_IDLE : ST_DROP;
                        end else begin
                            mem_wr_out   <= 1'b1;
                            mem_addr_out <= {page_q, offset_q};
                            mem_data_out <= rx_byte_in;
                            offset_q     <= offset_q + 8'h01;
                            count_q      <= count_q + 16'h0001;
                            need_open_q  <= (offset_q == 8'hff);
                            if (offset_q == 8'hff) begin
                                page_q <= ring_next(page_q, ring_first_page_q,
                                                    ring_end_page_q);
                            end
                        end
                    end
                    // an end strobe beside a blocked byte was already aborted above
                    if (rx_end_in && !(rx_byte_valid_in && open_blocked)) begin
                        status_q  <= rx_status_in;
                        hdr_idx_q <= `RRB_HDR_STATUS;
                        // page after the last one holding a byte of this frame; a last byte that opens a page beside the end strobe gives that page itself
                        if (rx_byte_valid_in && offset_q == 8'hff) begin
                            next_page_q <= ring_next(page_q, ring_first_page_q,
                                                     ring_end_page_q);
                        end else if (need_open_q) begin
                            next_page_q <= page_q;
                        end else begin
                            next_page_q <= ring_next(page_q, ring_first_page_q,
                                                     ring_end_page_q);
                        end
                        state_q <= ST_HDR;
                    end
                end
                ST_HDR: begin
                    // header goes to the frame's start page, byte by byte
                    mem_wr_out   <= 1'b1;
                    mem_addr_out <= {write_page_pointer_q, 6'b000000, hdr_idx_q};
                    case (hdr_idx_q)
                        `RRB_HDR_STATUS:    mem_data_out <= status_q;
                        `RRB_HDR_NEXT_PAGE: mem_data_out <= next_page_q;
                        `RRB_HDR_COUNT_LO:  mem_data_out <= count_q[7:0];
                        default:            mem_data_out <= count_q[15:8];
                    endcase
                    hdr_idx_q <= hdr_idx_q + 2'b01;
                    if (hdr_idx_q == `RRB_HDR_COUNT_HI) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_DROP: begin
                    // rest of an aborted frame is discarded
                    // the mac keeps sending until its end strobe; nothing reaches memory
                    if (rx_end_in) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // =====================================================================
    // ring limits, pointers and mode
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            ring_first_page_q    <= `RRB_RST_PAGE;
            ring_end_page_q      <= `RRB_RST_PAGE;
            write_page_pointer_q <= `RRB_RST_PAGE;
            protect_page_q       <= `RRB_RST_PAGE;
            extension_register_q <= `RRB_RST_BYTE;
            int_mask_q           <= 2'b00;
            host_last_q          <= 1'b1;
        end else begin
            if (reg_wr_in) begin
                case (reg_addr_in)
                    `RRB_OFF_RING_FIRST: ring_first_page_q    <= reg_wdata_in;
                    `RRB_OFF_RING_END:   ring_end_page_q      <= reg_wdata_in;
                    `RRB_OFF_EXTENSION:  extension_register_q <= reg_wdata_in;
                    `RRB_OFF_INT_MASK:   int_mask_q           <= reg_wdata_in[1:0];
                    default: begin
                    end
                endcase
            end
            // illegal ring limits (end on first or first+1) are not trapped here
            // the dma update at frame end outranks a host write in the same cycle
            if (done_event) begin
                write_page_pointer_q <= next_page_q;
            end else if (host_wr_write_ptr) begin
                write_page_pointer_q <= reg_wdata_in;
            end
            if (host_wr_protect_ptr) begin
                protect_page_q <= reg_wdata_in;
            end
            // whoever moved a pointer last decides full against empty
            if (done_event) begin
                host_last_q <= 1'b0;
            end else if (host_wr_protect_ptr || host_wr_write_ptr) begin
                host_last_q <= 1'b1;
            end
        end
    end

    // =====================================================================
    // sticky flags: a set in the clearing cycle survives
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            int_flags_q <= 2'b00;
            rx_result_q <= `RRB_RST_BYTE;
        end else begin
            if (reg_wr_in && reg_addr_in == `RRB_OFF_INT_FLAGS) begin
                int_flags_q <= (int_flags_q & ~reg_wdata_in[1:0]) |
                               {done_event, overwrite_event};
            end else begin
                int_flags_q <= int_flags_q | {done_event, overwrite_event};
            end
            // the result byte holds only the latest outcome, older ones are lost
            if (overwrite_event) begin
                rx_result_q <= 8'h01 << `RRB_RES_MISSED_FRAME;
            end else if (done_event) begin
                rx_result_q <= 8'h01 << `RRB_RES_RECEIVED_OK;
            end
        end
    end

    // =====================================================================
    // read port: data stand in the cycle after the strobe
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                `RRB_OFF_RING_FIRST:  reg_rdata_out <= ring_first_page_q;
                `RRB_OFF_RING_END:    reg_rdata_out <= ring_end_page_q;
                `RRB_OFF_WRITE_PTR:   reg_rdata_out <= write_page_pointer_q;
                `RRB_OFF_PROTECT_PTR: reg_rdata_out <= protect_page_q;
                `RRB_OFF_EXTENSION:   reg_rdata_out <= extension_register_q;
                `RRB_OFF_INT_FLAGS:   reg_rdata_out <= {6'b000000, int_flags_q};
                `RRB_OFF_INT_MASK:    reg_rdata_out <= {6'b000000, int_mask_q};
                `RRB_OFF_RX_RESULT:   reg_rdata_out <= rx_result_q;
                `RRB_OFF_UPPER_CTRL:  reg_rdata_out <= {5'b00000, ring_empty, 2'b00};
                default:              reg_rdata_out <= 8'h00;
            endcase
        end else begin
            // idle cycles read zero so a stale value cannot pass for fresh data
            reg_rdata_out <= 8'h00;
        end
    end

endmodule // rrb_dma

/* File: verilog/rrb_defines.vh */
// register offsets, field positions and reset values of the receive ring dma
// assumes inclusion by bare name from the design files
`ifndef RRB_DEFINES_VH
`define RRB_DEFINES_VH

// register offsets on the plain register port
`define RRB_OFF_RING_FIRST   4'h0
`define RRB_OFF_RING_END     4'h1
`define RRB_OFF_WRITE_PTR    4'h2
`define RRB_OFF_PROTECT_PTR  4'h3
`define RRB_OFF_EXTENSION    4'h4
`define RRB_OFF_INT_FLAGS    4'h5
`define RRB_OFF_INT_MASK     4'h6
`define RRB_OFF_RX_RESULT    4'h7
`define RRB_OFF_UPPER_CTRL   4'h8

// field positions
`define RRB_EXT_LIST_MODE    0
`define RRB_INT_OVERWRITE    0
`define RRB_INT_RECEIVED     1
`define RRB_RES_RECEIVED_OK  0
`define RRB_RES_MISSED_FRAME 4
`define RRB_UBR_RING_EMPTY   2

// reset values
`define RRB_RST_PAGE         8'h00
`define RRB_RST_BYTE         8'h00

// buffer layout: header bytes precede data in the first page
`define RRB_HDR_LEN          8'h04
`define RRB_HDR_STATUS       2'h0
`define RRB_HDR_NEXT_PAGE    2'h1
`define RRB_HDR_COUNT_LO     2'h2
`define RRB_HDR_COUNT_HI     2'h3

`endif

/* File: test/rrb_ram_model.sv */
// buffer ram model that stands behind the receive dma write port
// assumes one byte written per clock, on the dma's own rising edge
`timescale 1ns/10ps

module rrb_ram_model (
    input wire        ref_clk_in,
    input wire        mem_wr_in,
    input wire [15:0] mem_addr_in,
    input wire [7:0]  mem_data_in
);
    // ==========================================
    // storage
    logic [7:0] mem [0:65535];

    // cells never written stay unknown, so a stray read cannot pass for data
    always @(posedge ref_clk_in) begin
        if (mem_wr_in) begin
            mem[mem_addr_in] <= mem_data_in;
        end
    end
endmodule // rrb_ram_model

/* File: test/rrb_dma_monitor.sv */
// port checker for the receive ring dma
// assumes one clock domain and the reset of that domain
`timescale 1ns/10ps
`include "rrb_defines.vh"

module rrb_dma_monitor (
    input wire        ref_clk_in,
    input wire        rst_in,
    input wire [3:0]  reg_addr_in,
    input wire [7:0]  reg_wdata_in,
    input wire        reg_wr_in,
    input wire        reg_rd_in,
    input wire [7:0]  reg_rdata_out,
    input wire        rx_start_in,
    input wire        rx_byte_valid_in,
    input wire [7:0]  rx_byte_in,
    input wire        rx_end_in,
    input wire        rx_abort_out,
    input wire        mem_wr_out,
    input wire [15:0] mem_addr_out,
    input wire [7:0]  mem_data_out,
    input wire        list_mode_select_out
);
    // ==========================================
    // frame tracking
    reg  in_frame_q;
    reg  first_q;
    wire start_ok = rx_start_in && !list_mode_select_out && !in_frame_q;

    // an aborted frame leaves tracking after its abort, so only one whose blocked byte meets the end strobe is held to a header
    always @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            in_frame_q <= 1'b0;
            first_q    <= 1'b0;
        end else begin
            in_frame_q <= start_ok | (in_frame_q & ~rx_end_in & ~rx_abort_out);
            first_q    <= start_ok | (first_q & ~rx_byte_valid_in);
        end
    end

    // ==========================================
    // assertions
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    a_first_data_offset: assert property (first_q && in_frame_q && rx_byte_valid_in
        && !rx_abort_out |=> rx_abort_out || (mem_wr_out && mem_addr_out[7:0] == 8'h04))
        else $error("first data byte not at offset four");
    a_byte_to_memory: assert property (in_frame_q && rx_byte_valid_in && !rx_abort_out
        |=> rx_abort_out || (mem_wr_out && mem_data_out == $past(rx_byte_in)))
        else $error("received byte not written");
    a_header_order: assert property (rx_end_in && in_frame_q && !rx_abort_out
        |-> ##2 mem_wr_out && mem_addr_out[7:0] == 8'h00
        ##1 mem_wr_out && mem_addr_out[7:0] == 8'h01 && $stable(mem_addr_out[15:8])
        ##1 mem_wr_out && mem_addr_out[7:0] == 8'h02 && $stable(mem_addr_out[15:8])
        ##1 mem_wr_out && mem_addr_out[7:0] == 8'h03 && $stable(mem_addr_out[15:8]))
        else $error("header writes out of order");
    a_abort_one_cycle: assert property (rx_abort_out |=> !rx_abort_out)
        else $error("abort longer than one cycle");
    a_abort_no_write: assert property (rx_abort_out |-> !mem_wr_out)
        else $error("write beside abort");
    a_abort_has_cause: assert property (rx_abort_out |-> $past(rx_start_in || rx_byte_valid_in))
        else $error("abort without start or byte");
    a_list_mode_follow: assert property (reg_wr_in && reg_addr_in == `RRB_OFF_EXTENSION
        |=> list_mode_select_out == $past(reg_wdata_in[0]))
        else $error("list mode bit not taken");
    a_list_start_ignored: assert property (rx_start_in && list_mode_select_out && !in_frame_q
        |=> !rx_abort_out && !mem_wr_out) else $error("start acted on in list mode");
    a_upper_ctrl_bits: assert property (reg_rd_in && reg_addr_in == `RRB_OFF_UPPER_CTRL
        |=> (reg_rdata_out & 8'hfb) == 8'h00) else $error("upper control spare bits set");

    c_abort: cover property (rx_abort_out);
    c_header: cover property (rx_end_in && in_frame_q ##4 mem_wr_out);
    c_list_start: cover property (rx_start_in && list_mode_select_out);
endmodule // rrb_dma_monitor

bind rrb_dma rrb_dma_monitor u_rrb_dma_monitor (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .rx_start_in(rx_start_in),
    .rx_byte_valid_in(rx_byte_valid_in), .rx_byte_in(rx_byte_in), .rx_end_in(rx_end_in),
    .rx_abort_out(rx_abort_out), .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out), .list_mode_select_out(list_mode_select_out));

/* File: test/rrb_dma_tb.sv */
// self-checking bench for the receive ring dma with a buffer ram model
// assumes a 50 MHz clock and the register map of the shared defines
`timescale 1ns/10ps
`include "rrb_defines.vh"

module rrb_dma_tb;
    localparam logic [7:0] FP = 8'h10;
    localparam logic [7:0] EP = 8'h14;
    logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, st = 1'b0, bv = 1'b0, fe = 1'b0;
    logic [3:0] ra = 4'h0;
    logic [7:0] wd = 8'h00, rb = 8'h00, rs = 8'h00, v, ls;
    wire        abort, mwr, lms, irq;
    wire [15:0] maddr;
    wire [7:0]  rdat, mdat;
    logic [7:0] fb [0:1023];
    int         error_cnt = 0, check_count = 0, aborts = 0, a0;

    rrb_dma u_rrb_dma (.ref_clk_in(clk), .rst_in(rst), .reg_addr_in(ra), .reg_wdata_in(wd),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .rx_start_in(st),
        .rx_byte_valid_in(bv), .rx_byte_in(rb), .rx_end_in(fe), .rx_status_in(rs),
        .rx_abort_out(abort), .mem_wr_out(mwr), .mem_addr_out(maddr), .mem_data_out(mdat),
        .list_mode_select_out(lms), .irq_out(irq));
    rrb_ram_model u_rrb_ram_model (.ref_clk_in(clk), .mem_wr_in(mwr), .mem_addr_in(maddr),
        .mem_data_in(mdat));

    // ==========================================
    // clock, abort counting, watchdog
    initial forever #10 clk = ~clk;
    always @(posedge clk) if (abort) aborts <= aborts + 1;
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        $display("[FAIL] %0t: watchdog expired", $time);
        test_done;
    end

    // ==========================================
    // helpers
    task chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        ra <= a; wd <= d; wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data is taken at the edge that closes the cycle after the strobe
    task rchk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        ra <= a; rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdat, e);
    endtask
    function logic [7:0] nxt(input logic [7:0] p);
        return (p + 8'h01 == EP) ? FP : p + 8'h01;
    endfunction
    function logic [7:0] rm(input logic [15:0] a);
        return u_rrb_ram_model.mem[a];
    endfunction
    // random frame of n bytes from page sp; layout checked only if it should land
    task frame(input int n, input logic [7:0] sp, input bit ok);
        logic [7:0] p, off, s;
        int i;
        s = $urandom;
        @(posedge clk) st <= 1'b1;
        @(posedge clk) st <= 1'b0;
        for (i = 0; i < n; i++) begin
            fb[i] = $urandom;
            bv <= 1'b1; rb <= fb[i];
            @(posedge clk);
        end
        bv <= 1'b0; fe <= 1'b1; rs <= s;
        @(posedge clk) fe <= 1'b0;
        // last header byte reaches the ram model at the fifth edge after the one that samples the end strobe
        repeat (6) @(posedge clk);
        if (ok) begin
            p = sp; off = 8'h04; ls = s;
            for (i = 0; i < n; i++) begin
                chk(rm({p, off}), fb[i]);
                off++;
                if (off == 8'h00) p = nxt(p);
            end
            if (off != 8'h00) p = nxt(p);
            chk(rm({sp, 8'h00}), s);
            chk(rm({sp, 8'h01}), p);
            chk(rm({sp, 8'h02}), n[7:0]);
            chk(rm({sp, 8'h03}), n[15:8]);
            rchk(`RRB_OFF_WRITE_PTR, p);
        end
    endtask
    task tdone(input string name);
        $display("test %s done", name);
    endtask
    task test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================
    // tests
    initial begin
        void'($urandom(85));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(`RRB_OFF_WRITE_PTR, `RRB_RST_PAGE);
        rchk(`RRB_OFF_UPPER_CTRL, 8'h04);
        wrr(4'hc, 8'hff);
        rchk(4'hc, 8'h00);
        tdone("reset");
        wrr(`RRB_OFF_RING_FIRST, FP);
        wrr(`RRB_OFF_RING_END, EP);
        wrr(`RRB_OFF_WRITE_PTR, FP);
        wrr(`RRB_OFF_PROTECT_PTR, FP);
        wrr(`RRB_OFF_INT_MASK, 8'h01);
        frame(300, FP, 1'b1);
        rchk(`RRB_OFF_UPPER_CTRL, 8'h00);
        tdone("two_page");
        wrr(`RRB_OFF_PROTECT_PTR, 8'h12);
        frame(600, 8'h12, 1'b1);
        tdone("wrap");
        a0 = aborts;
        frame(400, 8'h11, 1'b0);
        chk(8'(aborts - a0), 8'h01);
        chk(rm(16'h1200), ls);
        rchk(`RRB_OFF_INT_FLAGS, 8'h03);
        rchk(`RRB_OFF_RX_RESULT, 8'h10);
        chk({7'h00, irq}, 8'h01);
        wrr(`RRB_OFF_INT_MASK, 8'h00);
        @(posedge clk);
        chk({7'h00, irq}, 8'h00);
        wrr(`RRB_OFF_INT_FLAGS, 8'h03);
        rchk(`RRB_OFF_INT_FLAGS, 8'h00);
        rchk(`RRB_OFF_WRITE_PTR, 8'h11);
        tdone("protect");
        frame(252, 8'h11, 1'b1);
        rchk(`RRB_OFF_UPPER_CTRL, 8'h00);
        a0 = aborts;
        frame(8, 8'h12, 1'b0);
        chk(8'(aborts - a0), 8'h01);
        wrr(`RRB_OFF_PROTECT_PTR, 8'h12);
        rchk(`RRB_OFF_UPPER_CTRL, 8'h04);
        tdone("full");
        wrr(`RRB_OFF_EXTENSION, 8'h01);
        @(posedge clk);
        chk({7'h00, lms}, 8'h01);
        a0 = aborts;
        frame(4, 8'h12, 1'b0);
        chk(8'(aborts - a0), 8'h00);
        rchk(`RRB_OFF_WRITE_PTR, 8'h12);
        wrr(`RRB_OFF_EXTENSION, 8'h00);
        @(posedge clk);
        chk({7'h00, lms}, 8'h00);
        tdone("list_mode");
        test_done;
    end
endmodule // rrb_dma_tb
